// *** host_model.sv ***
module host_model #(
  parameter int unsigned KICK_CYC = 200
) (
  // Clock and control
  input  wire logic clk,
  input  wire logic kick_en,
  input  wire logic reset_n,
  // Strobe
  output logic      watchdog_kick
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  initial begin
    watchdog_kick = 1'b1;
    cnt = 0;
    forever begin
      @(posedge clk);
      #1;
      cnt = (kick_en && reset_n) ? cnt + 1 : 0;
      watchdog_kick = (cnt % KICK_CYC) != KICK_CYC - 1;
    end
  end
endmodule : host_model

// *** interval_timer.sv ***
module interval_timer #(
  parameter int unsigned LIMIT = 10
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  // Control
  input  wire logic clear,
  input  wire logic adv,
  // Status
  output logic      done
);

  localparam int unsigned W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIM = W'(LIMIT);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Saturates so a long wait never wraps back to idle
  assign cnt_nxt = clear ? '0 : ((adv && cnt_r != LIM) ? cnt_r + W'(1) : cnt_r);
  assign done    = (cnt_r == LIM);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : interval_timer

// *** supervisor_chk.sv ***
module supervisor_chk #(
  parameter int unsigned RESET_TICKS    = 20,
  parameter int unsigned WATCHDOG_TICKS = 50,
  parameter int unsigned DEBOUNCE_TICKS = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Inputs
  input wire logic supply_ok,
  input wire logic sense_low,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick,
  // Outputs
  input wire logic reset_n,
  input wire logic reset,
  input wire logic early_warning_n,
  input wire logic watchdog_expired_n
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TK = supervisor_pkg::TICK_DIV;
  // Run lengths in cycles; the stretch starts only when every cause is gone
  logic [31:0] low_r, quiet_r, sense_r, ew_r, wd_r, gap_r;
  logic        seen_r, kick_prev_r;
  wire         kick_fell = kick_prev_r && !watchdog_kick;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {low_r, quiet_r, sense_r, ew_r, wd_r, gap_r} <= '0;
      seen_r      <= 1'b0;
      kick_prev_r <= 1'b1;
    end else begin
      low_r       <= supply_ok ? '0 : low_r + 1;
      quiet_r     <= (supply_ok && manual_reset_n) ? quiet_r + 1 : '0;
      sense_r     <= sense_low ? sense_r + 1 : '0;
      ew_r        <= early_warning_n ? '0 : ew_r + 1;
      wd_r        <= watchdog_expired_n ? '0 : wd_r + 1;
      gap_r       <= (reset_n && watchdog_expired_n && !kick_fell) ? gap_r + 1 : '0;
      seen_r      <= seen_r | supply_ok;
      kick_prev_r <= watchdog_kick;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence press_s; $fell(manual_reset_n); endsequence
  sequence warn_s; $fell(early_warning_n); endsequence
  pol_inverse_a: assert property (reset != reset_n)
    else $error("reset outputs not inverse");
  press_fast_a: assert property (press_s |-> ##2 !reset_n)
    else $error("press not seen in time");
  supply_low_a: assert property (low_r >= supervisor_pkg::SUPPLY_FILT_CYC + 3 |-> !reset_n)
    else $error("low supply without reset");
  dip_ignore_a: assert property (reset_n && supply_ok && $past(supply_ok) && $past(supply_ok, 2)
    && manual_reset_n && $past(manual_reset_n) |=> reset_n) else $error("reset without cause");
  fall_cause_a: assert property ($fell(reset_n) |-> $past(low_r, 2) >= supervisor_pkg::SUPPLY_FILT_CYC
    || !$past(manual_reset_n, 2)) else $error("reset without long dip or press");
  stretch_min_a: assert property ($rose(reset_n) |-> quiet_r >= RESET_TICKS * TK)
    else $error("reset stretch too short");
  warn_filter_a: assert property (warn_s |-> sense_r >= supervisor_pkg::SENSE_FILT_CYC)
    else $error("warning before filter time");
  warn_gate_a: assert property (warn_s |-> seen_r)
    else $error("warning before supply seen");
  warn_width_a: assert property ($rose(early_warning_n) |-> ew_r >= supervisor_pkg::EARLY_WARN_TICKS * TK)
    else $error("warning pulse too short");
  wd_width_a: assert property ($rose(watchdog_expired_n) |-> wd_r >= RESET_TICKS * TK)
    else $error("watchdog pulse too short");
  wd_bound_a: assert property (gap_r <= (WATCHDOG_TICKS + 2) * TK)
    else $error("watchdog did not expire");
  wd_early_a: assert property ($fell(watchdog_expired_n) |-> gap_r >= (WATCHDOG_TICKS - 1) * TK)
    else $error("watchdog expired early");
endmodule : supervisor_chk

bind supply_supervisor_watchdog supervisor_chk #(
  .RESET_TICKS(RESET_TICKS), .WATCHDOG_TICKS(WATCHDOG_TICKS), .DEBOUNCE_TICKS(DEBOUNCE_TICKS)
) i_chk (.clk, .resetn, .ce, .supply_ok, .sense_low, .manual_reset_n, .watchdog_kick,
  .reset_n, .reset, .early_warning_n, .watchdog_expired_n);

// *** supervisor_pkg.sv ***
package supervisor_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned TICK_NS          = 1000;
  localparam int unsigned TICK_DIV         = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W       = $clog2(TICK_DIV);
  localparam int unsigned US_PER_MS        = 1000;
  localparam int unsigned US_PER_S         = 1000000;

  // ----------------------------------------------------------------
  // Intervals, each in its own unit, then in ticks or cycles
  // ----------------------------------------------------------------
  localparam int unsigned RESET_MS         = 130;
  localparam int unsigned RESET_TICKS      = RESET_MS * US_PER_MS;
  localparam int unsigned WATCHDOG_S       = 1;
  localparam int unsigned WATCHDOG_TICKS   = WATCHDOG_S * US_PER_S;
  localparam int unsigned EARLY_WARN_US    = 200;
  localparam int unsigned EARLY_WARN_TICKS = EARLY_WARN_US;
  localparam int unsigned DEBOUNCE_MS      = 1;
  localparam int unsigned DEBOUNCE_TICKS   = DEBOUNCE_MS * US_PER_MS;
  // Least times: round up to whole cycles
  localparam int unsigned SENSE_FILT_NS    = 5000;
  localparam int unsigned SENSE_FILT_CYC   = (SENSE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SUPPLY_FILT_NS   = 2000;
  localparam int unsigned SUPPLY_FILT_CYC  = (SUPPLY_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest time: rounds down
  localparam int unsigned MR_ASSERT_NS     = 250;
  localparam int unsigned MR_ASSERT_CYC    = MR_ASSERT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Output bundle and its reset value
  // ----------------------------------------------------------------
  typedef struct packed {
    logic reset_n;
    logic reset;
    logic early_warning_n;
    logic watchdog_expired_n;
  } sup_out_t;

  localparam sup_out_t OUT_RESET = '{reset_n: 1'b0, reset: 1'b1, early_warning_n: 1'b1, watchdog_expired_n: 1'b1};

endpackage : supervisor_pkg

// *** supply_supervisor_watchdog.sv ***
// Operation
// - Reset asserts while the filtered supply comparator reports low supply.
// - Reset stays asserted at least 130 ms after power-up or supply recovery.
// - Manual reset input is active low; a press acts at once and only the release is debounced.
// - Manual reset stretch of 130 ms starts once the input has stayed high for the 1 ms debounce time.
// - Early-warning output pulses low at least 200 us on a sense trip.
// - Sense must stay below trip about 5 us before a warning fires.
// - No early warning until the supply has reached its trip level.
// - Watchdog counts only while reset is inactive, starting at release.
// - Strobe falling edge before expiry clears and restarts the watchdog.
// - Watchdog status asserts when no strobe edge arrives within 1 s.
// - Watchdog status stays low at least 130 ms after expiry.
// - Active-low reset output plus an active-high copy of opposite polarity.
// - Reset outputs assert within 250 ns of manual reset held low.
// - Supply dips shorter than 2 us cause no reset.
module supply_supervisor_watchdog #(
  parameter int unsigned RESET_TICKS    = supervisor_pkg::RESET_TICKS,
  parameter int unsigned WATCHDOG_TICKS = supervisor_pkg::WATCHDOG_TICKS,
  parameter int unsigned DEBOUNCE_TICKS = supervisor_pkg::DEBOUNCE_TICKS
) (
  // Clock, reset, enable
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  // Comparator results
  input  wire logic supply_ok,
  input  wire logic sense_low,
  // Pushbutton and host strobe
  input  wire logic manual_reset_n,
  input  wire logic watchdog_kick,
  // Outputs to the host
  output logic      reset_n,
  output logic      reset,
  output logic      early_warning_n,
  output logic      watchdog_expired_n
);

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam logic [supervisor_pkg::TICK_CNT_W-1:0] TICK_LAST =
    supervisor_pkg::TICK_CNT_W'(supervisor_pkg::TICK_DIV - 1);

  logic [supervisor_pkg::TICK_CNT_W-1:0] tick_cnt_r;
  logic                                  tick_r;
  logic                                  tick_wrap;

  assign tick_wrap = (tick_cnt_r == TICK_LAST);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (ce) begin
      tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + supervisor_pkg::TICK_CNT_W'(1);
      tick_r     <= tick_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Supply filter
  // ----------------------------------------------------------------
  logic supply_filt_done;
  logic supply_bad_r;
  logic power_seen_r;

  interval_timer #(.LIMIT(supervisor_pkg::SUPPLY_FILT_CYC)) u_supply_filt (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .clear  (supply_ok),
    .adv    (1'b1),
    .done   (supply_filt_done)
  );

  // Bad is assumed at power-up, so reset starts asserted
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      supply_bad_r <= 1'b1;
      power_seen_r <= 1'b0;
    end else if (ce) begin
      supply_bad_r <= supply_ok ? 1'b0 : (supply_filt_done ? 1'b1 : supply_bad_r);
      power_seen_r <= power_seen_r | supply_ok;
    end
  end

  // ----------------------------------------------------------------
  // Pushbutton
  // ----------------------------------------------------------------
  logic mr_low_r;
  logic mr_hold_r;
  logic mr_release_done;

  // release must stay high for the debounce time
  interval_timer #(.LIMIT(DEBOUNCE_TICKS)) u_debounce (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .clear  (mr_low_r),
    .adv    (tick_r),
    .done   (mr_release_done)
  );

  // Press takes effect at once; only the release is debounced, which keeps the assert path short
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mr_low_r  <= 1'b0;
      mr_hold_r <= 1'b0;
    end else if (ce) begin
      mr_low_r  <= ~manual_reset_n;
      mr_hold_r <= mr_low_r | (mr_hold_r & ~mr_release_done);
    end
  end

  // ----------------------------------------------------------------
  // Reset stretch
  // ----------------------------------------------------------------
  logic reset_cause;
  logic stretch_done;
  logic rst_act_r;
  logic rst_nxt;

  // press reaches the outputs one edge after it is sampled into mr_low_r
  assign reset_cause = supply_bad_r | mr_low_r | mr_hold_r;

  interval_timer #(.LIMIT(RESET_TICKS + 1)) u_stretch (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .clear  (reset_cause),
    .adv    (tick_r),
    .done   (stretch_done)
  );

  assign rst_nxt = reset_cause | ~stretch_done;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_act_r <= 1'b1;
    end else if (ce) begin
      rst_act_r <= rst_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Early warning
  // ----------------------------------------------------------------
  logic sense_trip;
  logic warn_act_r;
  logic warn_fired_r;
  logic warn_done;
  logic warn_start;

  // 5 us below trip before a warning
  interval_timer #(.LIMIT(supervisor_pkg::SENSE_FILT_CYC)) u_sense_filt (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .clear  (~sense_low),
    .adv    (1'b1),
    .done   (sense_trip)
  );

  // held off until supply has risen
  assign warn_start = sense_trip & power_seen_r & ~warn_fired_r;

  interval_timer #(.LIMIT(supervisor_pkg::EARLY_WARN_TICKS + 1)) u_warn (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .clear  (~warn_act_r),
    .adv    (tick_r),
    .done   (warn_done)
  );

  // One pulse per trip; a new one needs the sense to recover first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      warn_act_r   <= 1'b0;
      warn_fired_r <= 1'b0;
    end else if (ce) begin
      warn_act_r   <= warn_start | (warn_act_r & ~warn_done);
      warn_fired_r <= sense_trip & (warn_fired_r | warn_start);
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  logic kick_prev_r;
  logic kick_fall;
  logic wd_done;
  logic wd_fire;
  logic wds_act_r;
  logic wds_done;

  assign kick_fall = kick_prev_r & ~watchdog_kick;
  assign wd_fire   = wd_done & ~wds_act_r;

  // held clear while reset is active
  interval_timer #(.LIMIT(WATCHDOG_TICKS)) u_watchdog (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .clear  (rst_act_r | kick_fall | wds_act_r),
    .adv    (tick_r),
    .done   (wd_done)
  );

  // status low at least 130 ms
  interval_timer #(.LIMIT(RESET_TICKS + 1)) u_wds_pulse (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .clear  (~wds_act_r),
    .adv    (tick_r),
    .done   (wds_done)
  );

  // Strobe pulled high when idle, so the previous level starts high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kick_prev_r <= 1'b1;
      wds_act_r   <= 1'b0;
    end else if (ce) begin
      kick_prev_r <= watchdog_kick;
      wds_act_r   <= wd_fire | (wds_act_r & ~wds_done);
    end
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  supervisor_pkg::sup_out_t out_r;
  supervisor_pkg::sup_out_t out_nxt;

  // both reset polarities from one condition
  assign out_nxt = '{reset_n:            ~rst_nxt,
                     reset:              rst_nxt,
                     early_warning_n:    ~(warn_start | (warn_act_r & ~warn_done)),
                     watchdog_expired_n: ~(wd_fire | (wds_act_r & ~wds_done))};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_r <= supervisor_pkg::OUT_RESET;
    end else if (ce) begin
      out_r <= out_nxt;
    end
  end

  assign reset_n            = out_r.reset_n;
  assign reset              = out_r.reset;
  assign early_warning_n    = out_r.early_warning_n;
  assign watchdog_expired_n = out_r.watchdog_expired_n;

endmodule : supply_supervisor_watchdog

// *** supply_supervisor_watchdog_tb_top.sv ***
module supply_supervisor_watchdog_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Shortened counts keep the run brief
  localparam int RT = 20, WT = 50, DT = 5, TK = supervisor_pkg::TICK_DIV;
  logic clk, resetn, ce, supply_ok, sense_low, manual_reset_n, kick_en;
  logic watchdog_kick, reset_n, reset, early_warning_n, watchdog_expired_n;
  int   err_total, n_checks, n;
  supply_supervisor_watchdog #(.RESET_TICKS(RT), .WATCHDOG_TICKS(WT), .DEBOUNCE_TICKS(DT)) i_dut (
    .clk, .resetn, .ce, .supply_ok, .sense_low, .manual_reset_n, .watchdog_kick,
    .reset_n, .reset, .early_warning_n, .watchdog_expired_n);
  host_model i_host (.clk, .kick_en, .reset_n, .watchdog_kick);
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: level mismatch", $time);
    end
  endtask : chk
  task automatic chk_ge(input int got, input int lo);
    n_checks++;
    if (got < lo) begin
      err_total++;
      $display("Error at %0t: interval %0d under %0d", $time, got, lo);
    end
  endtask : chk_ge
  // Cycles until an output reaches a level; bounded so a hang cannot stall
  task automatic meas(input int sel, input logic lvl, output int c);
    logic v;
    c = 0;
    do begin
      step(1);
      c++;
      v = (sel == 0) ? reset_n : (sel == 1) ? early_warning_n : watchdog_expired_n;
    end while (v !== lvl && c < 30000);
    chk(v, lvl);
  endtask : meas
  task automatic t_power;
    step(100);
    chk(early_warning_n, 1'b1);
    supply_ok = 1'b1;
    meas(0, 1'b1, n);
    chk_ge(n, RT * TK);
    chk(early_warning_n, 1'b0);
    sense_low = 1'b0;
    meas(1, 1'b1, n);
  endtask : t_power
  task automatic t_dip;
    supply_ok = 1'b0;
    step(15);
    supply_ok = 1'b1;
    step(5);
    chk(reset_n, 1'b1);
    supply_ok = 1'b0;
    step(24);
    chk(reset, 1'b1);
    supply_ok = 1'b1;
    meas(0, 1'b1, n);
    chk_ge(n, RT * TK);
  endtask : t_dip
  task automatic t_manual;
    manual_reset_n = 1'b0;
    step(2);
    chk(reset_n, 1'b0);
    step(40);
    manual_reset_n = 1'b1;
    step(2);
    manual_reset_n = 1'b0;
    step(1);
    manual_reset_n = 1'b1;
    // Frozen enable must stretch the release by at least the frozen span
    step(20);
    ce = 1'b0;
    step(100);
    chk(reset_n, 1'b0);
    ce = 1'b1;
    meas(0, 1'b1, n);
    chk_ge(n + 120, (RT + DT - 1) * TK + 100);
  endtask : t_manual
  task automatic t_warn;
    sense_low = 1'b1;
    step(45);
    sense_low = 1'b0;
    step(10);
    chk(early_warning_n, 1'b1);
    sense_low = 1'b1;
    meas(1, 1'b0, n);
    chk_ge(n, supervisor_pkg::SENSE_FILT_CYC);
    meas(1, 1'b1, n);
    chk_ge(n, supervisor_pkg::EARLY_WARN_TICKS * TK);
    sense_low = 1'b0;
  endtask : t_warn
  task automatic t_wd;
    step(WT * TK * 3);
    chk(watchdog_expired_n, 1'b1);
    kick_en = 1'b0;
    manual_reset_n = 1'b0;
    step(3);
    manual_reset_n = 1'b1;
    meas(0, 1'b1, n);
    meas(2, 1'b0, n);
    chk_ge(n, (WT - 1) * TK);
    meas(2, 1'b1, n);
    chk_ge(n, RT * TK);
  endtask : t_wd
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    step(20000);
    err_total++;
    end_of_test();
  end
  initial begin
    resetn = 1'b0;
    supply_ok = 1'b0;
    sense_low = 1'b1;
    manual_reset_n = 1'b1;
    kick_en = 1'b1;
    ce = 1'b1;
    step(5);
    resetn = 1'b1;
    t_power();
    t_dip();
    t_manual();
    t_warn();
    t_wd();
    end_of_test();
  end
endmodule : supply_supervisor_watchdog_tb_top
